// ===== dv/hvp_checker.sv
// checker: port-level properties of the high-voltage pin block
`default_nettype none
module hvp_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire hvp_pkg::hvp_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic [3:0] pin_level,
  input wire logic pwm_mid_strobe,
  input wire logic [3:2] port_out_data,
  input wire hvp_pkg::hvp_fn_cfg_t pin2_fn_cfg,
  input wire hvp_pkg::hvp_fn_cfg_t pin3_fn_cfg,
  input wire hvp_pkg::hvp_led_cfg_t pin2_led_cfg,
  input wire hvp_pkg::hvp_led_cfg_t pin3_led_cfg,
  input wire logic [3:2] attenuator_route,
  input wire logic [3:2] pin_out,
  input wire logic [3:2] pin_oe,
  input wire logic shared_pin_irq_line,
  input wire logic wake_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // mapped bytes; the hole between the pin 2 fault register and the pin 3 function config stays unmapped
  wire logic mapped = sfr_req.addr >= hvp_pkg::ADDR_PIN2_FUNCTION_CONFIG &&
    sfr_req.addr <= hvp_pkg::ADDR_PIN3_EDGE_WAKE_IRQ && sfr_req.addr != 16'ha04b;
  // a pad moved within the synchroniser plus edge history latency
  sequence pin_moved;
    $past(pin_level, 3) != $past(pin_level, 4);
  endsequence
  // a register write or a mid-period fault sample has just been taken
  sequence sfr_or_strobe;
    $past(sfr_req.wr) || $past(pwm_mid_strobe);
  endsequence
  // quiet read, no write around it, returns the register behind the port
  property readback(logic [15:0] a, logic [7:0] v);
    sfr_req.rd && !sfr_req.wr && !$past(sfr_req.wr) && sfr_req.addr == a
      |=> sfr_rdata == $past(v);
  endproperty
  rdata_idle_a: assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned data");
  fn2_readback_a: assert property (readback(hvp_pkg::ADDR_PIN2_FUNCTION_CONFIG, pin2_fn_cfg))
    else $error("pin 2 function config read mismatch");
  fn3_readback_a: assert property (readback(hvp_pkg::ADDR_PIN3_FUNCTION_CONFIG, pin3_fn_cfg))
    else $error("pin 3 function config read mismatch");
  led_reserved_a: assert property ({pin2_led_cfg[6:5], pin3_led_cfg[6]} == 3'b000)
    else $error("reserved led config bit set");
  drain_only_a: assert property (pin_out == 2'b00)
    else $error("pad driven high");
  drain_off_a: assert property ((port_out_data & $past(port_out_data) & pin_oe) == 2'b00)
    else $error("pad pulled low while port bit is one");
  drain_on_a: assert property ($past(pin2_fn_cfg[4]) && pin2_fn_cfg[4] &&
      !port_out_data[2] && !$past(port_out_data[2]) |-> pin_oe[2])
    else $error("pad not pulled low for port bit zero");
  atten_route_a: assert property ($stable(pin2_fn_cfg) && $stable(pin3_fn_cfg)
      |-> attenuator_route == {pin3_fn_cfg[2], pin2_fn_cfg[2]})
    else $error("attenuator route differs from config");
  irq_sticky_a: assert property (shared_pin_irq_line && !sfr_req.wr |=> shared_pin_irq_line)
    else $error("shared line fell without a write");
  wake_sticky_a: assert property (wake_request && !sfr_req.wr |=> wake_request)
    else $error("wake request fell without a write");
  irq_cause_a: assert property ($rose(shared_pin_irq_line) |-> pin_moved or sfr_or_strobe)
    else $error("shared line rose without a cause");
  wake_cause_a: assert property ($rose(wake_request) |-> pin_moved)
    else $error("wake request rose without a pad edge");
endmodule
bind hvp_top hvp_checker i_chk (.clock, .rst_n, .sfr_req, .sfr_rdata, .pin_level,
  .pwm_mid_strobe, .port_out_data, .pin2_fn_cfg, .pin3_fn_cfg, .pin2_led_cfg, .pin3_led_cfg,
  .attenuator_route, .pin_out, .pin_oe, .shared_pin_irq_line, .wake_request);
`default_nettype wire

// ===== dv/hvp_partner.sv
// partner model: pads, led fault detectors and the pwm mid-period strobe
`default_nettype none
module hvp_partner #(parameter int PERIOD = 16) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] pad_drive,
  input wire logic [3:2] pin_oe,
  input wire logic [3:2] open_cmd,
  input wire logic [3:2] short_cmd,
  output logic [3:0] pin_level,
  output logic [3:2] open_detect_raw,
  output logic [3:2] short_detect_raw,
  output var logic pwm_mid_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // open-drain pad
  // an enabled pull-down wins over whatever drives the pad from outside
  assign pin_level = {pad_drive[3:2] & ~pin_oe, pad_drive[1:0]};
  // detectors follow the commanded led condition as plain levels
  assign open_detect_raw = open_cmd;
  assign short_detect_raw = short_cmd;
  // mid-period strobe
  // one pulse per pwm period; the pwm runs from the core clock, so it runs free
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      pwm_mid_strobe <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      pwm_mid_strobe <= (cnt == PERIOD / 2);
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench: register map, fault flags, filters and pin edge scenarios
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t %s", $time, m); end end
  localparam int OFS [11] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 10, 11};
  localparam logic [7:0] WMASK [11] = '{8'hff, 8'h9f, 8'hf0, 8'hff, 8'hbf, 8'hf0, 8'hff,
    8'hf0, 8'hf0, 8'hf0, 8'hf0};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  hvp_pkg::hvp_sfr_req_t sfr_req = '0;
  logic [3:2] port_out_data = 2'b00;
  logic [3:0] pad_drive = 4'h0;
  logic [3:2] open_cmd = 2'b00;
  logic [3:2] short_cmd = 2'b00;
  logic [7:0] sfr_rdata;
  logic [3:0] pin_level;
  logic [3:2] open_detect_raw, short_detect_raw, attenuator_route, pin_out, pin_oe;
  logic pwm_mid_strobe, shared_pin_irq_line, wake_request;
  hvp_pkg::hvp_fn_cfg_t pin2_fn_cfg, pin3_fn_cfg;
  hvp_pkg::hvp_led_cfg_t pin2_led_cfg, pin3_led_cfg;
  int n_errors = 0;
  int compares = 0;
  always #2.5 clock = ~clock;
  hvp_top i_dut (.clock, .rst_n, .sfr_req, .sfr_rdata, .pin_level, .open_detect_raw,
    .short_detect_raw, .pwm_mid_strobe, .port_out_data, .pin2_fn_cfg, .pin3_fn_cfg,
    .pin2_led_cfg, .pin3_led_cfg, .attenuator_route, .pin_out, .pin_oe,
    .shared_pin_irq_line, .wake_request);
  hvp_partner i_far (.clock, .rst_n, .pad_drive, .pin_oe, .open_cmd, .short_cmd, .pin_level,
    .open_detect_raw, .short_detect_raw, .pwm_mid_strobe);
  // expectations worked out from the register layout
  function automatic logic [15:0] adr(input int k);
    return 16'(hvp_pkg::ADDR_PIN2_FUNCTION_CONFIG + OFS[k]);
  endfunction
  function automatic logic [3:2] exp_oe(input logic [7:0] c3, input logic [7:0] c2,
      input logic [3:2] d);
    return {c3[4], c2[4]} & ~d;
  endfunction
  function automatic logic [7:0] flt(input logic [7:0] en, input int t, input logic lv,
      input logic fl);
    return en | (lv ? 8'h08 >> t : 8'h00) | (fl ? 8'h02 >> t : 8'h00);
  endfunction
  // all drivers move one nanosecond after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // strobe released one edge after it was taken, never re-raised in that step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    cyc(1);
    sfr_req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    cyc(1);
    sfr_req.rd = 1'b0;
    d = sfr_rdata;
    cyc(1);
  endtask
  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e, m)
  endtask
  // waits for n samples; a stuck pwm counts as a mismatch
  task automatic strobes(input int n);
    for (int k = 0; k < 200 && n > 0; k++) begin
      cyc(1);
      if (pwm_mid_strobe === 1'b1) n--;
    end
    if (n > 0) begin
      n_errors++;
      results();
    end
    cyc(2);
  endtask
  task automatic fault(input int p, input int t, input logic v);
    if (t == 0) open_cmd[p] = v;
    else short_cmd[p] = v;
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    logic [7:0] vals [11];
    logic [7:0] en;
    logic [15:0] a;
    int p, t, k, thr;
    thr = $urandom(70473);
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    cyc(1);
    for (k = 0; k < 11; k++) chk_reg(adr(k), 8'h00, "reset value");
    wr(16'ha04b, 8'hff);
    chk_reg(16'ha04b, 8'h00, "unmapped");
    for (k = 0; k < 11; k++) begin
      vals[k] = 8'($urandom);
      wr(adr(k), vals[k]);
      chk_reg(adr(k), vals[k] & WMASK[k], "readback");
    end
    `CHK(pin2_fn_cfg, vals[0], "fn2 out")
    `CHK(pin3_fn_cfg, vals[3], "fn3 out")
    `CHK(pin2_led_cfg, vals[1] & 8'h9f, "led2 out")
    `CHK(pin3_led_cfg, vals[4] & 8'hbf, "led3 out")
    // edge enables go first so the pad moves below raise nothing
    for (k = 10; k >= 0; k--) begin
      if (k == 3) begin
        for (t = 0; t < 4; t++) begin
          port_out_data = 2'(t);
          cyc(3);
          `CHK(pin_oe, exp_oe(vals[3], vals[0], port_out_data), "pull-down")
          `CHK(attenuator_route, {vals[3][2], vals[0][2]}, "route")
          `CHK(pin_out, 2'b00, "drive high")
        end
      end
      wr(adr(k), 8'h00);
    end
    for (p = 2; p < 4; p++) begin
      for (t = 0; t < 2; t++) begin
        a = adr(p == 2 ? 2 : 5);
        en = 8'h40 | (8'h20 >> t);
        wr(a, en);
        strobes(1);
        fault(p, t, 1'b1);
        strobes(1);
        chk_reg(a, flt(en, t, 1, 1), "fault set");
        `CHK(shared_pin_irq_line, 1'b1, "fault irq")
        fault(p, t, 1'b0);
        strobes(1);
        chk_reg(a, flt(en, t, 0, 1), "latched");
        wr(a, (en & 8'h3f) | 8'h03);
        chk_reg(a, flt(en & 8'h3f, t, 0, 1), "ones keep");
        `CHK(shared_pin_irq_line, 1'b0, "irq masked")
        wr(a, 8'h00);
        chk_reg(a, 8'h00, "cleared");
        wr(a, 8'h40);
        fault(p, t, 1'b1);
        strobes(2);
        chk_reg(a, 8'h40, "detect off");
        `CHK(shared_pin_irq_line, 1'b0, "irq off")
        fault(p, t, 1'b0);
        wr(a, 8'h00);
      end
    end
    // filtered assert and release on pin 3
    thr = 1 + ($urandom % 6);
    wr(hvp_pkg::ADDR_FAULT_FILTER_COUNTS, {4'(thr), 4'h3});
    a = hvp_pkg::ADDR_PIN3_FAULT_STATUS_IRQ;
    for (t = 0; t < 2; t++) begin
      k = (t == 0) ? thr : 3;
      en = 8'h80 | (8'h20 >> t);
      wr(a, en);
      strobes(1);
      fault(3, t, 1'b1);
      for (p = 1; p <= k; p++) begin
        strobes(1);
        chk_reg(a, flt(en, t, p == k, p == k), "filter up");
      end
      fault(3, t, 1'b0);
      for (p = 1; p <= k; p++) begin
        strobes(1);
        chk_reg(a, flt(en, t, p < k, 1), "filter down");
      end
      wr(a, 8'h00);
    end
    // pad edges, wake and shared line
    for (p = 0; p < 4; p++) begin
      a = adr(7 + p);
      wr(a, 8'he0);
      pad_drive[p] = 1'b1;
      cyc(6);
      chk_reg(a, 8'hee, "rise flags");
      `CHK(shared_pin_irq_line, 1'b1, "edge irq")
      `CHK(wake_request, 1'b1, "wake")
      wr(a, 8'hef);
      chk_reg(a, 8'hee, "ones keep");
      pad_drive[p] = 1'b0;
      cyc(6);
      chk_reg(a, 8'hee, "fall off");
      wr(a, 8'h10);
      `CHK(shared_pin_irq_line, 1'b0, "irq cleared")
      `CHK(wake_request, 1'b0, "wake cleared")
      pad_drive[p] = 1'b1;
      cyc(6);
      pad_drive[p] = 1'b0;
      cyc(6);
      chk_reg(a, 8'h11, "fall only");
      `CHK(shared_pin_irq_line, 1'b0, "no irq")
      wr(a, 8'h00);
    end
    results();
  end
endmodule
`default_nettype wire

// ===== pkg/hvp_pkg.sv
// package: register map, field layout and bus request type of the high-voltage pin block
`default_nettype none
package hvp_pkg;
  // register byte addresses on the special function register bus
  localparam logic [15:0] ADDR_PIN2_FUNCTION_CONFIG = 16'ha048;
  localparam logic [15:0] ADDR_PIN2_LED_SINK_CONFIG = 16'ha049;
  localparam logic [15:0] ADDR_PIN2_FAULT_STATUS_IRQ = 16'ha04a;
  localparam logic [15:0] ADDR_PIN3_FUNCTION_CONFIG = 16'ha04c;
  localparam logic [15:0] ADDR_PIN3_LED_SINK_CONFIG = 16'ha04d;
  localparam logic [15:0] ADDR_PIN3_FAULT_STATUS_IRQ = 16'ha04e;
  localparam logic [15:0] ADDR_FAULT_FILTER_COUNTS = 16'ha04f;
  localparam logic [15:0] ADDR_PIN0_EDGE_WAKE_IRQ = 16'ha050;
  localparam logic [15:0] ADDR_PIN1_EDGE_WAKE_IRQ = 16'ha051;
  localparam logic [15:0] ADDR_PIN2_EDGE_WAKE_IRQ = 16'ha052;
  localparam logic [15:0] ADDR_PIN3_EDGE_WAKE_IRQ = 16'ha053;
  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // fault status register bit positions
  localparam int FAULT_FILTER_ENABLE = 7;
  localparam int FAULT_IRQ_ENABLE = 6;
  localparam int OPEN_DETECT_ENABLE = 5;
  localparam int SHORT_DETECT_ENABLE = 4;
  localparam int OPEN_LIVE_STATUS = 3;
  localparam int SHORT_LIVE_STATUS = 2;
  localparam int OPEN_FAULT_FLAG = 1;
  localparam int SHORT_FAULT_FLAG = 0;
  // edge / wake register bit positions
  localparam int WAKE_SOURCE_ENABLE = 7;
  localparam int PIN_IRQ_ENABLE = 6;
  localparam int RISING_DETECT_ENABLE = 5;
  localparam int FALLING_DETECT_ENABLE = 4;
  localparam int WAKE_FLAG = 3;
  localparam int PIN_IRQ_FLAG = 2;
  localparam int RISING_EDGE_FLAG = 1;
  localparam int FALLING_EDGE_FLAG = 0;
  // filter register nibbles
  localparam int OPEN_FILTER_COUNT_LSB = 4;
  localparam int SHORT_FILTER_COUNT_LSB = 0;
  // hardware-owned bits of the fault and edge registers, and the empty filter count
  localparam logic [7:0] FAULT_FLAG_MASK = 8'h03;
  localparam logic [7:0] FAULT_LIVE_MASK = 8'h0c;
  localparam logic [7:0] EDGE_FLAG_MASK = 8'h0f;
  localparam logic [3:0] FILTER_ZERO = 4'h0;

  // general configuration of pins 2 and 3, bit 7 down to bit 0
  typedef struct packed {
    logic master_serial_enable;
    logic converter_route_enable;
    logic spi_role_enable;
    logic port_bit_function_enable;
    logic pwm_output_enable;
    logic attenuator_enable;
    logic input_buffer_enable;
    logic pullup_enable;
  } hvp_fn_cfg_t;

  // led sink configuration; bias bit exists on pin 3 only
  typedef struct packed {
    logic current_sink_enable;
    logic unused_6;
    logic thermistor_bias_enable;
    logic [4:0] full_scale_trim;
  } hvp_led_cfg_t;

  // special function register access, same clock as the block
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hvp_sfr_req_t;
endpackage
`default_nettype wire

// ===== src/hvp_top.sv
// high-voltage pin fault detection, configuration and pin interrupt block
//
// Summary of operation
// RULE1: filter enable routes open/short assert and deassert through the digital filter.
// RULE2: open detect enable low forces the open status deasserted.
// RULE3: short detect enable low forces the short status deasserted.
// RULE4: live open/short bits refresh once per pwm cycle, sampled mid-period.
// RULE5: short fault sets a latched flag, interrupting when fault irq enabled.
// RULE6: open fault sets a latched flag, interrupting when fault irq enabled.
// RULE7: upper filter nibble sets pwm cycles an open must persist.
// RULE8: lower filter nibble sets pwm cycles a short must persist.
// RULE9: filters count up while condition present, down while absent.
// RULE10: attenuator enable turns on one-sixth path to the converter input.
// RULE11: software never enables converter path and differential sense together.
// RULE12: pin 2 config holds serial data, converter, spi input, port, blue pwm.
// RULE13: pin 3 config holds serial clock, converter, spi output, port, white pwm.
// RULE14: each pin config has input buffer enable and pull-up enable.
// RULE15: led config has sink enable bit 7 and five-bit trim bits 4..0.
// RULE16: pin 3 led config has a thermistor bias current enable.
// RULE17: each of four pins is an interrupt and wake source, own enables.
// RULE18: all pin interrupts go out on one shared pin interrupt line.
// RULE19: wake enable plus wake event sets a sticky wake flag.
// RULE20: irq enable plus interrupt event sets a sticky pin irq flag.
// RULE21: enabled rising or falling edges set sticky edge flags.
// RULE22: every register of this block resets to all zeros.
// RULE23: general output only pulls down; writing one leaves the pin floating.
// RULE24: writing zero clears a flag, one keeps it; hardware set wins.
// RULE25: shared line asserts while any pin flag or enabled fault flag is set.
`default_nettype none
module hvp_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire hvp_pkg::hvp_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] pin_level,
  input wire logic [3:2] open_detect_raw,
  input wire logic [3:2] short_detect_raw,
  input wire logic pwm_mid_strobe,
  input wire logic [3:2] port_out_data,
  output hvp_pkg::hvp_fn_cfg_t pin2_fn_cfg,
  output hvp_pkg::hvp_fn_cfg_t pin3_fn_cfg,
  output hvp_pkg::hvp_led_cfg_t pin2_led_cfg,
  output hvp_pkg::hvp_led_cfg_t pin3_led_cfg,
  output logic [3:2] attenuator_route,
  output logic [3:2] pin_out,
  output logic [3:2] pin_oe,
  output logic shared_pin_irq_line,
  output logic wake_request
);

  typedef struct packed {
    logic [1:0][7:0] fn_cfg;
    logic [1:0][7:0] led_cfg;
    logic [1:0][7:0] fault;
    logic [7:0] filter_counts;
    logic [3:0][7:0] edge_reg;
    logic [1:0][3:0] open_cnt;
    logic [1:0][3:0] short_cnt;
    logic [1:0] open_filt;
    logic [1:0] short_filt;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [3:0] pin_prev;
    logic [2:0] prev_valid;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic [1:0] oe;
    logic [1:0] atten;
  } hvp_state_t;

  hvp_state_t st;
  hvp_state_t next_st;

  // one pwm-cycle step of an up/down fault filter: returns {state, count}
  function automatic logic [4:0] hvp_filt_step(input logic state, input logic [3:0] cnt,
                                              input logic [3:0] thr, input logic present);
    logic [3:0] c;
    logic s;
    c = cnt;
    s = state;
    if (present) begin
      if (c < thr) begin
        c = c + 4'h1;
      end
      if (c >= thr) begin
        s = 1'b1;
      end
    end else begin
      if (c != hvp_pkg::FILTER_ZERO) begin
        c = c - 4'h1;
      end
      if (c == hvp_pkg::FILTER_ZERO) begin
        s = 1'b0;
      end
    end
    return {s, c};
  endfunction

  // software write to a register holding sticky flags: zero clears, one keeps
  function automatic logic [7:0] hvp_flag_write(input logic [7:0] cur, input logic [7:0] wd,
                                               input logic [7:0] flags, input logic [7:0] ro);
    return (wd & ~flags & ~ro) | (cur & ro) | (cur & wd & flags);
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [1:0] open_raw;
    logic [1:0] short_raw;
    logic [3:0] pin_now;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [4:0] step;
    logic [3:0] open_thr;
    logic [3:0] short_thr;
    logic open_now;
    logic short_now;
    logic wr_hit;
    logic any_irq;
    logic any_wake;
    hvp_pkg::hvp_fn_cfg_t fc;
    open_raw = '0;
    short_raw = '0;
    pin_now = '0;
    rise = '0;
    fall = '0;
    step = '0;
    open_thr = '0;
    short_thr = '0;
    open_now = 1'b0;
    short_now = 1'b0;
    wr_hit = 1'b0;
    any_irq = 1'b0;
    any_wake = 1'b0;
    fc = '0;
    next_st = st;

    // pins and detector outputs are asynchronous: two flops before use
    next_st.sync1 = {short_detect_raw, open_detect_raw, pin_level};
    next_st.sync2 = st.sync1;
    pin_now = st.sync2[3:0];
    open_raw = st.sync2[5:4];
    short_raw = st.sync2[7:6];

    // no edges until the synchroniser holds real levels after reset
    next_st.pin_prev = pin_now;
    next_st.prev_valid = {st.prev_valid[1:0], 1'b1};
    rise = pin_now & ~st.pin_prev & {4{st.prev_valid[2]}};
    fall = ~pin_now & st.pin_prev & {4{st.prev_valid[2]}};

    // software writes; flag bits obey write-zero-to-clear
    if (sfr_req.wr) begin
      wr_hit = 1'b1;
      unique case (sfr_req.addr)
        // RULE12: pin 2 function enables
        hvp_pkg::ADDR_PIN2_FUNCTION_CONFIG: next_st.fn_cfg[0] = sfr_req.wdata;
        // RULE15: pin 2 sink enable and trim
        hvp_pkg::ADDR_PIN2_LED_SINK_CONFIG: begin
          next_st.led_cfg[0] = sfr_req.wdata & 8'h9f;
        end
        // RULE13: pin 3 function enables
        hvp_pkg::ADDR_PIN3_FUNCTION_CONFIG: next_st.fn_cfg[1] = sfr_req.wdata;
        // RULE16: pin 3 keeps the bias bit too
        hvp_pkg::ADDR_PIN3_LED_SINK_CONFIG: begin
          next_st.led_cfg[1] = sfr_req.wdata & 8'hbf;
        end
        hvp_pkg::ADDR_FAULT_FILTER_COUNTS: next_st.filter_counts = sfr_req.wdata;
        // RULE24: fault flags clear on zero
        hvp_pkg::ADDR_PIN2_FAULT_STATUS_IRQ: begin
          next_st.fault[0] = hvp_flag_write(st.fault[0], sfr_req.wdata,
                                            hvp_pkg::FAULT_FLAG_MASK, hvp_pkg::FAULT_LIVE_MASK);
        end
        hvp_pkg::ADDR_PIN3_FAULT_STATUS_IRQ: begin
          next_st.fault[1] = hvp_flag_write(st.fault[1], sfr_req.wdata,
                                            hvp_pkg::FAULT_FLAG_MASK, hvp_pkg::FAULT_LIVE_MASK);
        end
        // RULE24: edge and wake flags clear on zero
        hvp_pkg::ADDR_PIN0_EDGE_WAKE_IRQ: begin
          next_st.edge_reg[0] = hvp_flag_write(st.edge_reg[0], sfr_req.wdata,
                                               hvp_pkg::EDGE_FLAG_MASK, 8'h00);
        end
        hvp_pkg::ADDR_PIN1_EDGE_WAKE_IRQ: begin
          next_st.edge_reg[1] = hvp_flag_write(st.edge_reg[1], sfr_req.wdata,
                                               hvp_pkg::EDGE_FLAG_MASK, 8'h00);
        end
        hvp_pkg::ADDR_PIN2_EDGE_WAKE_IRQ: begin
          next_st.edge_reg[2] = hvp_flag_write(st.edge_reg[2], sfr_req.wdata,
                                               hvp_pkg::EDGE_FLAG_MASK, 8'h00);
        end
        hvp_pkg::ADDR_PIN3_EDGE_WAKE_IRQ: begin
          next_st.edge_reg[3] = hvp_flag_write(st.edge_reg[3], sfr_req.wdata,
                                               hvp_pkg::EDGE_FLAG_MASK, 8'h00);
        end
        default: wr_hit = 1'b0;
      endcase
    end

    // RULE7: open persistence threshold from upper nibble
    open_thr = st.filter_counts[hvp_pkg::OPEN_FILTER_COUNT_LSB +: 4];
    // RULE8: short persistence threshold from lower nibble
    short_thr = st.filter_counts[hvp_pkg::SHORT_FILTER_COUNT_LSB +: 4];

    // fault detection for pins 2 and 3
    for (int p = 0; p < 2; p++) begin
      // RULE4: filters move and live bits set only at mid-pwm samples
      if (pwm_mid_strobe) begin
        // RULE9: up/down persistence counting
        step = hvp_filt_step(st.open_filt[p], st.open_cnt[p], open_thr, open_raw[p]);
        next_st.open_filt[p] = step[4];
        next_st.open_cnt[p] = step[3:0];
        step = hvp_filt_step(st.short_filt[p], st.short_cnt[p], short_thr, short_raw[p]);
        next_st.short_filt[p] = step[4];
        next_st.short_cnt[p] = step[3:0];
        // RULE1: filtered result replaces the raw sample when enabled
        if (st.fault[p][hvp_pkg::FAULT_FILTER_ENABLE]) begin
          open_now = next_st.open_filt[p];
          short_now = next_st.short_filt[p];
        end else begin
          open_now = open_raw[p];
          short_now = short_raw[p];
        end
        // RULE2: open status forced low while detection disabled
        open_now = open_now & next_st.fault[p][hvp_pkg::OPEN_DETECT_ENABLE];
        // RULE3: short status forced low while detection disabled
        short_now = short_now & next_st.fault[p][hvp_pkg::SHORT_DETECT_ENABLE];
        next_st.fault[p][hvp_pkg::OPEN_LIVE_STATUS] = open_now;
        next_st.fault[p][hvp_pkg::SHORT_LIVE_STATUS] = short_now;
        // RULE6: open fault latches; set beats a same-cycle clear
        if (open_now) begin
          next_st.fault[p][hvp_pkg::OPEN_FAULT_FLAG] = 1'b1;
        end
        // RULE5: short fault latches; set beats a same-cycle clear
        if (short_now) begin
          next_st.fault[p][hvp_pkg::SHORT_FAULT_FLAG] = 1'b1;
        end
      end
      // RULE2: disabling detection drops the live bit at once
      if (!next_st.fault[p][hvp_pkg::OPEN_DETECT_ENABLE]) begin
        next_st.fault[p][hvp_pkg::OPEN_LIVE_STATUS] = 1'b0;
      end
      // RULE3: same for the short live bit
      if (!next_st.fault[p][hvp_pkg::SHORT_DETECT_ENABLE]) begin
        next_st.fault[p][hvp_pkg::SHORT_LIVE_STATUS] = 1'b0;
      end
    end

    // RULE17: every pin has its own edge, irq and wake enables
    for (int p = 0; p < 4; p++) begin
      logic r_ev;
      logic f_ev;
      r_ev = rise[p] & st.edge_reg[p][hvp_pkg::RISING_DETECT_ENABLE];
      f_ev = fall[p] & st.edge_reg[p][hvp_pkg::FALLING_DETECT_ENABLE];
      // RULE21: sticky edge flags
      if (r_ev) begin
        next_st.edge_reg[p][hvp_pkg::RISING_EDGE_FLAG] = 1'b1;
      end
      if (f_ev) begin
        next_st.edge_reg[p][hvp_pkg::FALLING_EDGE_FLAG] = 1'b1;
      end
      // RULE20: sticky pin irq flag on an enabled edge event
      if ((r_ev | f_ev) && st.edge_reg[p][hvp_pkg::PIN_IRQ_ENABLE]) begin
        next_st.edge_reg[p][hvp_pkg::PIN_IRQ_FLAG] = 1'b1;
      end
      // RULE19: sticky wake flag on an enabled edge event
      if ((r_ev | f_ev) && st.edge_reg[p][hvp_pkg::WAKE_SOURCE_ENABLE]) begin
        next_st.edge_reg[p][hvp_pkg::WAKE_FLAG] = 1'b1;
      end
      any_irq = any_irq | next_st.edge_reg[p][hvp_pkg::PIN_IRQ_FLAG];
      any_wake = any_wake | next_st.edge_reg[p][hvp_pkg::WAKE_FLAG];
    end

    // fault flags only interrupt when their pin's fault irq enable is set
    for (int p = 0; p < 2; p++) begin
      // RULE5: short flag gated by fault irq enable
      // RULE6: open flag gated by fault irq enable
      any_irq = any_irq | (next_st.fault[p][hvp_pkg::FAULT_IRQ_ENABLE] &
                (next_st.fault[p][hvp_pkg::OPEN_FAULT_FLAG] |
                 next_st.fault[p][hvp_pkg::SHORT_FAULT_FLAG]));
    end
    // RULE18: one shared line for all pin interrupts
    // RULE25: level follows the or of all pending causes
    next_st.irq = any_irq;
    next_st.wake = any_wake;

    // output paths for pins 2 and 3
    for (int p = 0; p < 2; p++) begin
      fc = hvp_pkg::hvp_fn_cfg_t'(next_st.fn_cfg[p]);
      // RULE23: open drain, pull low only for a zero data bit
      next_st.oe[p] = fc.port_bit_function_enable & ~port_out_data[p + 2];
      // RULE10: attenuated voltage reaches the converter input
      next_st.atten[p] = fc.attenuator_enable;
    end

    // registered read data, one cycle after the read strobe
    next_st.rdata = 8'h00;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        hvp_pkg::ADDR_PIN2_FUNCTION_CONFIG: next_st.rdata = st.fn_cfg[0];
        hvp_pkg::ADDR_PIN2_LED_SINK_CONFIG: next_st.rdata = st.led_cfg[0];
        hvp_pkg::ADDR_PIN2_FAULT_STATUS_IRQ: next_st.rdata = st.fault[0];
        hvp_pkg::ADDR_PIN3_FUNCTION_CONFIG: next_st.rdata = st.fn_cfg[1];
        hvp_pkg::ADDR_PIN3_LED_SINK_CONFIG: next_st.rdata = st.led_cfg[1];
        hvp_pkg::ADDR_PIN3_FAULT_STATUS_IRQ: next_st.rdata = st.fault[1];
        hvp_pkg::ADDR_FAULT_FILTER_COUNTS: next_st.rdata = st.filter_counts;
        hvp_pkg::ADDR_PIN0_EDGE_WAKE_IRQ: next_st.rdata = st.edge_reg[0];
        hvp_pkg::ADDR_PIN1_EDGE_WAKE_IRQ: next_st.rdata = st.edge_reg[1];
        hvp_pkg::ADDR_PIN2_EDGE_WAKE_IRQ: next_st.rdata = st.edge_reg[2];
        hvp_pkg::ADDR_PIN3_EDGE_WAKE_IRQ: next_st.rdata = st.edge_reg[3];
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // RULE22: all state clears to zero on reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops, except the constant pin_out
  assign sfr_rdata = st.rdata;
  // RULE14: buffer and pull-up bits reach the pad via the config outputs
  assign pin2_fn_cfg = hvp_pkg::hvp_fn_cfg_t'(st.fn_cfg[0]);
  assign pin3_fn_cfg = hvp_pkg::hvp_fn_cfg_t'(st.fn_cfg[1]);
  assign pin2_led_cfg = hvp_pkg::hvp_led_cfg_t'(st.led_cfg[0]);
  assign pin3_led_cfg = hvp_pkg::hvp_led_cfg_t'(st.led_cfg[1]);
  assign attenuator_route = st.atten;
  // pad only ever drives low, so the data bit is constant zero
  assign pin_out = 2'b00;
  assign pin_oe = st.oe;
  assign shared_pin_irq_line = st.irq;
  assign wake_request = st.wake;

endmodule
`default_nettype wire
